// *** hw/traffic_conflict_monitor.sv ***
// Top of the traffic conflict monitor: fault latching, flash control and display
module traffic_conflict_monitor #(
	parameter int unsigned TICK_CYCLES = tcm_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [tcm_pkg::NCH-1:0] green,
	input wire logic [tcm_pkg::NCH-1:0] yellow,
	input wire logic [tcm_pkg::NCH-1:0] red,
	input wire logic [tcm_pkg::NCH-1:0] walk,
	input wire logic [tcm_pkg::NCH-1:0][tcm_pkg::NCH-1:0] compat,
	input wire logic twelve_ch,
	input wire logic gy_check_en,
	input wire logic [tcm_pkg::NCH-1:0] gwyr_check_en,
	input wire logic [tcm_pkg::DUAL_W-1:0] dual_trip_ms,
	input wire logic [3:0] seq_sel,
	input wire logic line_ok,
	input wire logic cu_volt_ok,
	input wire logic sup24a_ok,
	input wire logic sup24b_ok,
	input wire logic manual_reset,
	input wire logic [tcm_pkg::HIST_AW-1:0] hist_idx,
	output logic stop_timing,
	output logic flash_xfer,
	output logic monitor_present,
	output logic ind_conflict,
	output logic ind_red,
	output logic ind_seq,
	output logic ind_24a,
	output logic ind_24b,
	output logic ind_cu_volt,
	output logic ind_gy,
	output logic ind_gwyr,
	output logic [tcm_pkg::NCH-1:0] ch_ind,
	output logic [tcm_pkg::HIST_CW-1:0] hist_code,
	output logic [tcm_pkg::HIST_AW:0] hist_count
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [tcm_pkg::TICK_W-1:0] tick_cnt;
		logic tick;
		tcm_pkg::pwr_state_t st;
		logic [tcm_pkg::PWR_W-1:0] pwr_cnt;
		logic [tcm_pkg::HIST_CW-1:0] flt;
		logic [tcm_pkg::NCH-1:0] ch_flt;
		logic [tcm_pkg::NCH-1:0] ch_ind;
		logic cpl;
		logic mrst_prev;
		logic flash;
		logic present;
	} mon_state_t;

	localparam mon_state_t MON_RST = '{
		tick_cnt: '0,
		tick: 1'b0,
		st: tcm_pkg::PWR_ST_RST,
		pwr_cnt: '0,
		flt: '0,
		ch_flt: '0,
		ch_ind: '0,
		cpl: 1'b0,
		mrst_prev: 1'b0,
		flash: tcm_pkg::FLASH_RST,
		present: 1'b0
	};

	localparam logic [tcm_pkg::TICK_W-1:0] TICK_LAST = tcm_pkg::TICK_W'(TICK_CYCLES - 1);

	mon_state_t s_q;
	mon_state_t s_d;
	mon_if bus();

	logic [tcm_pkg::NCH-1:0] ch_mask;
	logic [tcm_pkg::NCH-1:0] act;
	logic [tcm_pkg::NCH-1:0] red_ch;
	logic [tcm_pkg::NCH-1:0] seq_ch;
	logic [tcm_pkg::NCH-1:0] gy_ch;
	logic [tcm_pkg::NCH-1:0] gr_ch;
	logic [tcm_pkg::HIST_CW-1:0] trip;
	logic [3:0] sel_c;
	logic pwr_bad;
	logic clr;
	logic live;
	logic freeze;
	logic manual_hold;

	// ------------------------------------------------------------
	// Conflict decode
	// ------------------------------------------------------------
	// Any two active channels whose pair is not marked compatible
	function automatic logic conflict_any(
		input logic [tcm_pkg::NCH-1:0] a,
		input logic [tcm_pkg::NCH-1:0][tcm_pkg::NCH-1:0] ok
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < tcm_pkg::NCH; i++) begin
			for (int j = i + 1; j < tcm_pkg::NCH; j++) begin
				if (a[i] && a[j] && !ok[i][j]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	// ------------------------------------------------------------
	// Checker configuration
	// ------------------------------------------------------------
	// Out-of-range settings are clamped rather than rejected
	always_comb begin
		if (dual_trip_ms < tcm_pkg::DUAL_MIN_MS) begin
			bus.dual_ms = tcm_pkg::DUAL_MIN_MS;
		end else if (dual_trip_ms > tcm_pkg::DUAL_MAX_MS) begin
			bus.dual_ms = tcm_pkg::DUAL_MAX_MS;
		end else begin
			bus.dual_ms = dual_trip_ms;
		end
	end

	// Sequence window is 2.0 s plus 0.1 s per step
	assign sel_c = (seq_sel > tcm_pkg::SEQ_SEL_MAX) ? tcm_pkg::SEQ_SEL_MAX : seq_sel;
	assign bus.seq_ms = tcm_pkg::SEQ_MIN_MS + tcm_pkg::SEQ_STEP_MS * {8'h00, sel_c};

	// Feed the channel checker
	assign bus.tick = s_q.tick;
	assign bus.green = green;
	assign bus.yellow = yellow;
	assign bus.red = red;
	assign bus.walk = walk;
	assign bus.gy_en = gy_check_en;
	assign bus.gwyr_en = gwyr_check_en;

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	chan_check u_chk (
		.mclk(mclk),
		.rst_n(rst_n),
		.bus(bus)
	);

	fault_history u_hist (
		.mclk(mclk),
		.rst_n(rst_n),
		.bus(bus)
	);

	// ------------------------------------------------------------
	// Fault detection
	// ------------------------------------------------------------
	// Field checks are muted while power is bad or recovering, since
	// dark or flashing heads would raise false red failures
	always_comb begin
		ch_mask = twelve_ch ? '1 : tcm_pkg::MASK_SMALL;
		act = (green | yellow | walk) & ch_mask;
		pwr_bad = ~line_ok | ~cu_volt_ok | ~sup24a_ok | ~sup24b_ok;
		live = (s_q.st == tcm_pkg::ST_RUN) & ~pwr_bad;
		red_ch = ch_mask & ~(red | green | yellow) & {tcm_pkg::NCH{live}};
		seq_ch = bus.seq_trip & ch_mask & {tcm_pkg::NCH{live}};
		gy_ch = bus.gy_trip & ch_mask & {tcm_pkg::NCH{live}};
		gr_ch = bus.gr_trip & ch_mask & {tcm_pkg::NCH{live}};
		trip = '0;
		trip[tcm_pkg::F_CONFLICT] = live & conflict_any(act, compat);
		trip[tcm_pkg::F_RED] = |red_ch;
		trip[tcm_pkg::F_SEQ] = |seq_ch;
		trip[tcm_pkg::F_24A] = ~sup24a_ok;
		trip[tcm_pkg::F_24B] = ~sup24b_ok;
		trip[tcm_pkg::F_CUV] = ~cu_volt_ok;
		trip[tcm_pkg::F_GY] = |gy_ch;
		trip[tcm_pkg::F_GWYR] = |gr_ch;
	end

	// History gets one record, holding every trip bit, in each cycle that raises any new fault type
	assign bus.hist_wr = |(trip & ~s_q.flt);
	assign bus.hist_code = trip;
	assign bus.hist_idx = hist_idx;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Latches are not cleared by power loss, only by manual reset
	always_comb begin
		s_d = s_q;
		// Millisecond tick
		s_d.tick = 1'b0;
		if (s_q.tick_cnt == TICK_LAST) begin
			s_d.tick_cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
		end

		// Manual reset acts on its rising edge only
		s_d.mrst_prev = manual_reset;
		clr = manual_reset & ~s_q.mrst_prev;

		// A new trip in the clear cycle wins over the clear
		s_d.flt = (s_q.flt & ~{tcm_pkg::HIST_CW{clr}}) | trip;
		s_d.ch_flt = (s_q.ch_flt & ~{tcm_pkg::NCH{clr}}) | red_ch | seq_ch;

		// Indicators capture the channels active at the conflict trip
		freeze = s_q.flt[tcm_pkg::F_CONFLICT] & s_d.flt[tcm_pkg::F_CONFLICT];
		if (freeze) begin
			s_d.ch_ind = s_q.ch_ind;
		end else begin
			s_d.ch_ind = act | s_d.ch_flt;
		end

		// Conflict seen when power drops blocks automatic recovery
		s_d.cpl = (s_q.cpl & ~(clr & ~pwr_bad))
			| (pwr_bad & s_q.flt[tcm_pkg::F_CONFLICT]);

		// Power recovery sequence
		unique case (s_q.st)
			tcm_pkg::ST_RUN: begin
				if (pwr_bad) begin
					s_d.st = tcm_pkg::ST_PWR_DOWN;
				end
			end
			tcm_pkg::ST_PWR_DOWN: begin
				s_d.pwr_cnt = '0;
				if (!pwr_bad) begin
					s_d.st = tcm_pkg::ST_PWR_FLASH;
				end
			end
			tcm_pkg::ST_PWR_FLASH: begin
				if (pwr_bad) begin
					s_d.st = tcm_pkg::ST_PWR_DOWN;
					s_d.pwr_cnt = '0;
				end else if (s_q.pwr_cnt >= tcm_pkg::PWR_FLASH_MS) begin
					s_d.st = tcm_pkg::ST_RUN;
					s_d.pwr_cnt = '0;
				end else if (s_q.tick) begin
					s_d.pwr_cnt = s_q.pwr_cnt + 13'h0001;
				end
			end
			default: begin
				s_d.st = tcm_pkg::ST_PWR_DOWN;
			end
		endcase

		// Flash and stop timing follow every fault source
		manual_hold = |(s_d.flt & tcm_pkg::MANUAL_MASK);
		s_d.flash = manual_hold | s_d.cpl | (s_d.st != tcm_pkg::ST_RUN);
		s_d.present = 1'b1;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= MON_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Reset value is flashing so an unconfigured monitor stays safe
	assign stop_timing = s_q.flash;
	assign flash_xfer = s_q.flash;
	assign monitor_present = s_q.present;

	// Per-fault indications
	assign ind_conflict = s_q.flt[tcm_pkg::F_CONFLICT];
	assign ind_red = s_q.flt[tcm_pkg::F_RED];
	assign ind_seq = s_q.flt[tcm_pkg::F_SEQ];
	assign ind_24a = s_q.flt[tcm_pkg::F_24A];
	assign ind_24b = s_q.flt[tcm_pkg::F_24B];
	assign ind_cu_volt = s_q.flt[tcm_pkg::F_CUV];
	assign ind_gy = s_q.flt[tcm_pkg::F_GY];
	assign ind_gwyr = s_q.flt[tcm_pkg::F_GWYR];
	assign ch_ind = s_q.ch_ind;

	// History readback
	assign hist_code = bus.hist_rd;
	assign hist_count = bus.hist_cnt;
endmodule

// *** hw/tcm_pkg.sv ***
// Shared constants and types for the traffic conflict monitor
package tcm_pkg;

	// ------------------------------------------------------------
	// Channel count and clocking
	// ------------------------------------------------------------
	localparam int NCH = 12;
	localparam logic [NCH-1:0] MASK_SMALL = 12'h03f; // Low six channels
	localparam int CLK_HZ = 40_000_000;
	localparam int MS_PER_S = 1000;
	// Cycles per millisecond tick, derived from the clock rate
	localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
	localparam int TICK_W = 16;

	// ------------------------------------------------------------
	// Dual indication timing, in milliseconds
	// ------------------------------------------------------------
	localparam int DUAL_W = 10;
	localparam logic [DUAL_W-1:0] DUAL_PASS_MS = 10'h2bc; // 700 ms never trips
	localparam logic [DUAL_W-1:0] DUAL_MIN_MS = 10'h2bd; // 701 ms
	localparam logic [DUAL_W-1:0] DUAL_MAX_MS = 10'h3e8; // 1000 ms

	// ------------------------------------------------------------
	// Sequence (missing yellow) timing, in milliseconds
	// ------------------------------------------------------------
	localparam int SEQ_W = 12;
	localparam logic [SEQ_W-1:0] SEQ_MIN_MS = 12'h7d0; // 2.0 s
	localparam logic [SEQ_W-1:0] SEQ_MAX_MS = 12'haf0; // 2.8 s
	localparam logic [SEQ_W-1:0] SEQ_STEP_MS = 12'h064; // 0.1 s per step
	localparam logic [3:0] SEQ_SEL_MAX = 4'h8;

	// ------------------------------------------------------------
	// Power recovery flash period
	// ------------------------------------------------------------
	localparam int PWR_W = 13;
	localparam logic [PWR_W-1:0] PWR_FLASH_MS = 13'h1770; // 6000 ms

	// ------------------------------------------------------------
	// Fault history and fault code bits
	// ------------------------------------------------------------
	localparam int HIST_AW = 4;
	localparam int HIST_CW = 8;
	localparam logic [HIST_AW:0] HIST_DEPTH = 5'h10;
	localparam int F_CONFLICT = 0;
	localparam int F_RED = 1;
	localparam int F_SEQ = 2;
	localparam int F_24A = 3;
	localparam int F_24B = 4;
	localparam int F_CUV = 5;
	localparam int F_GY = 6;
	localparam int F_GWYR = 7;
	// Faults that need a manual reset before normal operation
	localparam logic [HIST_CW-1:0] MANUAL_MASK = 8'hc7;

	// ------------------------------------------------------------
	// Power recovery states and reset values
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_RUN, ST_PWR_DOWN, ST_PWR_FLASH} pwr_state_t;
	localparam pwr_state_t PWR_ST_RST = ST_PWR_FLASH;
	localparam logic FLASH_RST = 1'b1;

endpackage

// *** hw/mon_if.sv ***
// Carrier between the monitor core, the channel checker and the history store
interface mon_if;
	logic tick;
	logic [tcm_pkg::NCH-1:0] green;
	logic [tcm_pkg::NCH-1:0] yellow;
	logic [tcm_pkg::NCH-1:0] red;
	logic [tcm_pkg::NCH-1:0] walk;
	logic gy_en;
	logic [tcm_pkg::NCH-1:0] gwyr_en;
	logic [tcm_pkg::DUAL_W-1:0] dual_ms;
	logic [tcm_pkg::SEQ_W-1:0] seq_ms;
	logic [tcm_pkg::NCH-1:0] gy_trip;
	logic [tcm_pkg::NCH-1:0] gr_trip;
	logic [tcm_pkg::NCH-1:0] seq_trip;
	logic hist_wr;
	logic [tcm_pkg::HIST_CW-1:0] hist_code;
	logic [tcm_pkg::HIST_AW-1:0] hist_idx;
	logic [tcm_pkg::HIST_CW-1:0] hist_rd;
	logic [tcm_pkg::HIST_AW:0] hist_cnt;

	modport top(
		output tick, green, yellow, red, walk, gy_en, gwyr_en, dual_ms, seq_ms,
		output hist_wr, hist_code, hist_idx,
		input gy_trip, gr_trip, seq_trip, hist_rd, hist_cnt
	);
	modport chk(
		input tick, green, yellow, red, walk, gy_en, gwyr_en, dual_ms, seq_ms,
		output gy_trip, gr_trip, seq_trip
	);
	modport hist(
		input hist_wr, hist_code, hist_idx,
		output hist_rd, hist_cnt
	);
endinterface

// *** hw/chan_check.sv ***
// Per-channel dual indication and missing yellow timers
module chan_check (
	input wire logic mclk,
	input wire logic rst_n,
	mon_if.chk bus
);
	typedef struct packed {
		logic [tcm_pkg::NCH-1:0] prev_g;
		logic [tcm_pkg::NCH-1:0] armed;
		logic [tcm_pkg::NCH-1:0][tcm_pkg::DUAL_W-1:0] gy_cnt;
		logic [tcm_pkg::NCH-1:0][tcm_pkg::DUAL_W-1:0] gr_cnt;
		logic [tcm_pkg::NCH-1:0][tcm_pkg::SEQ_W-1:0] sq_cnt;
	} chk_state_t;

	chk_state_t s_q;
	chk_state_t s_d;
	logic [tcm_pkg::NCH-1:0] gy_on;
	logic [tcm_pkg::NCH-1:0] gr_on;

	// ------------------------------------------------------------
	// Overlap and sequence counters
	// ------------------------------------------------------------
	// Counters saturate so a long overlap holds its trip level
	always_comb begin
		s_d = s_q;
		gy_on = '0;
		gr_on = '0;
		for (int i = 0; i < tcm_pkg::NCH; i++) begin
			gy_on[i] = (bus.green[i] | (bus.gy_en & bus.walk[i])) & bus.yellow[i];
			gr_on[i] = (bus.green[i] | (bus.gwyr_en[i] & (bus.walk[i] | bus.yellow[i])))
				& bus.red[i];
			// Continuous overlap only; any gap restarts the count
			if (!gy_on[i]) begin
				s_d.gy_cnt[i] = '0;
			end else if (bus.tick && s_q.gy_cnt[i] < bus.dual_ms) begin
				s_d.gy_cnt[i] = s_q.gy_cnt[i] + 10'h001;
			end
			if (!gr_on[i]) begin
				s_d.gr_cnt[i] = '0;
			end else if (bus.tick && s_q.gr_cnt[i] < bus.dual_ms) begin
				s_d.gr_cnt[i] = s_q.gr_cnt[i] + 10'h001;
			end
			// Missing yellow after green ends
			s_d.prev_g[i] = bus.green[i];
			if (bus.green[i] | bus.yellow[i]) begin
				s_d.armed[i] = 1'b0;
				s_d.sq_cnt[i] = '0;
			end else if (s_q.prev_g[i]) begin
				s_d.armed[i] = 1'b1;
				s_d.sq_cnt[i] = '0;
			end else if (s_q.armed[i] && bus.tick && s_q.sq_cnt[i] < bus.seq_ms) begin
				s_d.sq_cnt[i] = s_q.sq_cnt[i] + 12'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// Trip levels
	// ------------------------------------------------------------
	for (genvar c = 0; c < tcm_pkg::NCH; c++) begin : g_trip
		assign bus.gy_trip[c] = (s_q.gy_cnt[c] >= bus.dual_ms);
		assign bus.gr_trip[c] = (s_q.gr_cnt[c] >= bus.dual_ms);
		assign bus.seq_trip[c] = s_q.armed[c] & (s_q.sq_cnt[c] >= bus.seq_ms);
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// *** hw/fault_history.sv ***
// Ring store of fault records, newest first on readback
module fault_history (
	input wire logic mclk,
	input wire logic rst_n,
	mon_if.hist bus
);
	typedef struct packed {
		logic [tcm_pkg::HIST_DEPTH-1:0][tcm_pkg::HIST_CW-1:0] mem;
		logic [tcm_pkg::HIST_AW-1:0] wr_ptr;
		logic [tcm_pkg::HIST_AW:0] count;
		logic [tcm_pkg::HIST_CW-1:0] rd;
	} hist_state_t;

	hist_state_t s_q;
	hist_state_t s_d;

	// ------------------------------------------------------------
	// Record and report
	// ------------------------------------------------------------
	// Oldest record is overwritten once the store is full
	always_comb begin
		s_d = s_q;
		if (bus.hist_wr) begin
			s_d.mem[s_q.wr_ptr] = bus.hist_code;
			s_d.wr_ptr = s_q.wr_ptr + 4'h1;
			if (s_q.count < tcm_pkg::HIST_DEPTH) begin
				s_d.count = s_q.count + 5'h01;
			end
		end
		s_d.rd = s_q.mem[s_q.wr_ptr - bus.hist_idx - 4'h1];
	end

	assign bus.hist_rd = s_q.rd;
	assign bus.hist_cnt = s_q.count;

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// *** dv/tcm_checker_asserts.sv ***
// Concurrent checks on the traffic conflict monitor ports
module tcm_checker #(
	parameter int unsigned TICK_CYCLES = tcm_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [tcm_pkg::NCH-1:0] green,
	input wire logic [tcm_pkg::NCH-1:0] yellow,
	input wire logic [tcm_pkg::NCH-1:0] red,
	input wire logic [tcm_pkg::NCH-1:0] walk,
	input wire logic line_ok,
	input wire logic cu_volt_ok,
	input wire logic sup24a_ok,
	input wire logic sup24b_ok,
	input wire logic manual_reset,
	input wire logic stop_timing,
	input wire logic flash_xfer,
	input wire logic monitor_present,
	input wire logic ind_conflict,
	input wire logic ind_red,
	input wire logic ind_seq,
	input wire logic ind_24a,
	input wire logic ind_cu_volt,
	input wire logic ind_gy,
	input wire logic ind_gwyr,
	input wire logic [tcm_pkg::NCH-1:0] ch_ind,
	input wire logic [tcm_pkg::HIST_AW:0] hist_count
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Overlap duration counters
	// ------------------------------------------------------------
	localparam int LO = 699 * TICK_CYCLES;
	localparam int HI = 1001 * TICK_CYCLES + 4;
	logic [31:0] ovl_q, ovl_d, run_q, run_d;
	logic ovl, must;
	// Wide overlap overstates the span, so the early check stays safe
	assign ovl = |(((green | walk) & yellow) | ((green | walk | yellow) & red));
	// Limitation: overlaps handed from one channel to another count as one
	assign must = |((green & yellow) | (green & red));
	always_comb begin
		ovl_d = ovl ? ovl_q + 32'h0000_0001 : 32'h0000_0000;
		run_d = (must && !stop_timing) ? run_q + 32'h0000_0001 : 32'h0000_0000;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ovl_q <= 32'h0000_0000;
			run_q <= 32'h0000_0000;
		end else begin
			ovl_q <= ovl_d;
			run_q <= run_d;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	flash_follow_a: assert property (flash_xfer == stop_timing)
		else $error("flash differs from stop timing");
	present_hold_a: assert property ($past(rst_n) |-> monitor_present)
		else $error("monitor not present");
	manual_flash_a: assert property ((ind_conflict || ind_red || ind_seq || ind_gy
		|| ind_gwyr) |-> stop_timing) else $error("latched fault without flash");
	latch_keep_a: assert property (ind_conflict && !manual_reset |=> ind_conflict)
		else $error("conflict dropped without reset");
	supply_trip_a: assert property (!sup24a_ok |=> ind_24a && stop_timing)
		else $error("supply fault missed");
	volt_trip_a: assert property (!cu_volt_ok |=> ind_cu_volt && stop_timing)
		else $error("controller voltage fault missed");
	outage_flash_a: assert property (!line_ok |=> stop_timing)
		else $error("outage without flash");
	lamp_freeze_a: assert property (ind_conflict && $past(ind_conflict)
		|-> $stable(ch_ind)) else $error("channel lamps moved after conflict");
	early_trip_a: assert property ($rose(ind_gy) || $rose(ind_gwyr) |-> ovl_q >= LO)
		else $error("overlap tripped too early");
	late_trip_a: assert property (run_q == HI |-> stop_timing)
		else $error("overlap not tripped in time");
	// Record and latch land on the same edge, so compare against the edge before the rise
	hist_step_a: assert property ($rose(ind_conflict)
		&& $past(hist_count) < 5'h10 |-> hist_count == $past(hist_count) + 5'h01)
		else $error("no history record");
	resume_ok_a: assert property ($fell(stop_timing) |-> line_ok && cu_volt_ok
		&& sup24a_ok && sup24b_ok) else $error("resumed with bad power");
	// Main scenarios reached
	cover property ($rose(ind_conflict));
	cover property ($rose(ind_seq));
	cover property ($fell(stop_timing));
endmodule

bind traffic_conflict_monitor tcm_checker #(.TICK_CYCLES(TICK_CYCLES)) tcm_checker_i (
	.mclk, .rst_n, .green, .yellow, .red, .walk, .line_ok, .cu_volt_ok, .sup24a_ok,
	.sup24b_ok, .manual_reset, .stop_timing, .flash_xfer, .monitor_present, .ind_conflict,
	.ind_red, .ind_seq, .ind_24a, .ind_cu_volt, .ind_gy, .ind_gwyr, .ch_ind, .hist_count
);

// *** dv/field_ctrl_model.sv ***
// Behavioural controller unit and field terminals facing the monitor
module field_ctrl_model (
	input wire logic mclk,
	input wire logic [tcm_pkg::NCH-1:0] cmd_g,
	input wire logic [tcm_pkg::NCH-1:0] cmd_y,
	input wire logic [tcm_pkg::NCH-1:0] cmd_r,
	input wire logic flash_xfer,
	input wire logic monitor_present,
	output logic [tcm_pkg::NCH-1:0] green,
	output logic [tcm_pkg::NCH-1:0] yellow,
	output logic [tcm_pkg::NCH-1:0] red,
	output logic [tcm_pkg::NCH-1:0] walk,
	output logic cab_flash
);
	timeunit 1ns;
	timeprecision 1ps;
	// Load switches settle one edge after the command
	always_ff @(posedge mclk) begin
		green <= cmd_g;
		yellow <= cmd_y;
		red <= cmd_r;
	end
	// No pedestrian heads in this cabinet
	assign walk = '0;
	// Interlock: a pulled monitor must also flash the cabinet
	assign cab_flash = flash_xfer | ~monitor_present;
endmodule

// *** dv/traffic_conflict_monitor_test.sv ***
// Self-checking bench for the traffic conflict monitor
module traffic_conflict_monitor_test;
	timeunit 1ns;
	timeprecision 1ps;
	// Short tick keeps the six second recovery affordable
	localparam int TK = 2;
	logic mclk, rst_n, twelve_ch, gy_check_en, line_ok, cu_volt_ok, sup24a_ok, sup24b_ok;
	logic manual_reset, stop_timing, flash_xfer, monitor_present, cab_flash;
	logic ind_conflict, ind_red, ind_seq, ind_24a, ind_24b, ind_cu_volt, ind_gy, ind_gwyr;
	logic [11:0] green, yellow, red, walk, cmd_g, cmd_y, cmd_r, gwyr_check_en, ch_ind;
	logic [11:0][11:0] compat;
	logic [9:0] dual_trip_ms;
	logic [3:0] seq_sel, hist_idx;
	logic [7:0] hist_code;
	logic [4:0] hist_count;
	int n_errors = 0;
	int n_tests = 0;

	traffic_conflict_monitor #(.TICK_CYCLES(TK)) traffic_conflict_monitor_i (
		.mclk, .rst_n, .green, .yellow, .red, .walk, .compat, .twelve_ch, .gy_check_en,
		.gwyr_check_en, .dual_trip_ms, .seq_sel, .line_ok, .cu_volt_ok, .sup24a_ok,
		.sup24b_ok, .manual_reset, .hist_idx, .stop_timing, .flash_xfer, .monitor_present,
		.ind_conflict, .ind_red, .ind_seq, .ind_24a, .ind_24b, .ind_cu_volt, .ind_gy,
		.ind_gwyr, .ch_ind, .hist_code, .hist_count
	);
	field_ctrl_model field_ctrl_model_i (
		.mclk, .cmd_g, .cmd_y, .cmd_r, .flash_xfer, .monitor_present, .green, .yellow,
		.red, .walk, .cab_flash
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic chk_vec(input logic [11:0] got, input logic [11:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	// Present a field state and let the latch edge pass
	task automatic field(input logic [11:0] g, input logic [11:0] y, input logic [11:0] r);
		@(posedge mclk);
		cmd_g <= g;
		cmd_y <= y;
		cmd_r <= r;
		repeat (4) @(negedge mclk);
	endtask
	task automatic wait_ms(input int n);
		repeat (n * TK) @(negedge mclk);
	endtask
	task automatic mreset;
		@(posedge mclk);
		manual_reset <= 1'b1;
		repeat (2) @(posedge mclk);
		manual_reset <= 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task automatic supply(input logic v);
		@(posedge mclk);
		cu_volt_ok <= v;
		sup24a_ok <= v;
		sup24b_ok <= v;
		repeat (3) @(negedge mclk);
	endtask
	// Walk both conflicting channels out through yellow to red
	task automatic conflict_tail;
		field(12'h001, 12'h002, 12'hffc);
		field(12'h000, 12'h001, 12'hffe);
		field(12'h000, 12'h000, 12'hfff);
	endtask
	task automatic print_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Whole run is near 50000 cycles
	initial begin
		repeat (80000) @(posedge mclk);
		n_errors++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		manual_reset = 1'b0;
		line_ok = 1'b1;
		supply_init: begin
			cu_volt_ok = 1'b1;
			sup24a_ok = 1'b1;
			sup24b_ok = 1'b1;
		end
		twelve_ch = 1'b1;
		gy_check_en = 1'b1;
		gwyr_check_en = 12'hfff;
		compat = '1;
		compat[0][1] = 1'b0;
		compat[1][0] = 1'b0;
		dual_trip_ms = 10'h000;
		seq_sel = 4'hf;
		hist_idx = 4'h0;
		cmd_g = 12'h000;
		cmd_y = 12'h000;
		cmd_r = 12'hfff;
		repeat (5) @(negedge mclk);
		chk_bit(cab_flash, 1'b1, "cabinet not flashing");
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(negedge mclk);
		chk_bit(monitor_present, 1'b1, "monitor absent");
		chk_bit(stop_timing, 1'b1, "no power-up flash");
		wait_ms(6010);
		chk_bit(stop_timing, 1'b0, "power-up flash stuck");
		// Conflicting greens, frozen lamps, manual clear
		field(12'h003, 12'h000, 12'hffc);
		chk_bit(ind_conflict, 1'b1, "conflict missed");
		chk_bit(flash_xfer, 1'b1, "no flash on conflict");
		chk_vec(ch_ind, 12'h003, "lamps at conflict");
		conflict_tail();
		chk_vec(ch_ind, 12'h003, "lamps not frozen");
		chk_vec({7'h00, hist_count}, 12'h001, "history count");
		chk_vec({4'h0, hist_code}, 12'h001, "conflict record");
		mreset();
		chk_bit(stop_timing, 1'b0, "flash after reset");
		// Six channel cabinet ignores a dark upper channel
		@(posedge mclk);
		twelve_ch <= 1'b0;
		field(12'h000, 12'h000, 12'heff);
		chk_bit(ind_red, 1'b0, "upper channel not masked");
		field(12'h000, 12'h000, 12'hfff);
		@(posedge mclk);
		twelve_ch <= 1'b1;
		// Dark channel two
		field(12'h000, 12'h000, 12'hffb);
		chk_bit(ind_red, 1'b1, "red failure missed");
		chk_vec(ch_ind, 12'h004, "red fault lamp");
		field(12'h000, 12'h000, 12'hfff);
		chk_vec({4'h0, hist_code}, 12'h002, "red record");
		@(posedge mclk);
		hist_idx <= 4'h1;
		repeat (3) @(negedge mclk);
		chk_vec({4'h0, hist_code}, 12'h001, "older record");
		mreset();
		chk_bit(ind_red, 1'b0, "red not cleared");
		// Overlaps against a threshold clamped up to 701 ms, then set to 1000 ms
		field(12'h008, 12'h008, 12'hff7);
		wait_ms(696);
		field(12'h000, 12'h008, 12'hff7);
		chk_bit(ind_gy, 1'b0, "short overlap tripped");
		field(12'h000, 12'h010, 12'hfff);
		wait_ms(693);
		chk_bit(ind_gwyr, 1'b0, "early red overlap");
		wait_ms(12);
		chk_bit(ind_gwyr, 1'b1, "yellow-red missed");
		field(12'h000, 12'h000, 12'hfff);
		mreset();
		@(posedge mclk);
		dual_trip_ms <= tcm_pkg::DUAL_MAX_MS;
		field(12'h008, 12'h008, 12'hff7);
		wait_ms(994);
		chk_bit(ind_gy, 1'b0, "overlap tripped early");
		wait_ms(8);
		chk_bit(ind_gy, 1'b1, "long overlap missed");
		field(12'h000, 12'h008, 12'hff7);
		field(12'h000, 12'h000, 12'hfff);
		mreset();
		// Missing yellow with the window clamped to 2.8 s
		field(12'h020, 12'h000, 12'hfdf);
		field(12'h000, 12'h000, 12'hfff);
		wait_ms(2794);
		chk_bit(ind_seq, 1'b0, "sequence early");
		wait_ms(10);
		chk_bit(ind_seq, 1'b1, "sequence missed");
		chk_vec(ch_ind, 12'h020, "sequence lamp");
		// Yellow must show before the clear, or the trip would set again
		field(12'h000, 12'h020, 12'hfdf);
		mreset();
		// Supply faults recover on their own
		supply(1'b0);
		chk_bit(ind_24b, 1'b1, "second supply missed");
		supply(1'b1);
		wait_ms(5990);
		chk_bit(stop_timing, 1'b1, "recovery too short");
		wait_ms(20);
		chk_bit(stop_timing, 1'b0, "no automatic return");
		chk_bit(ind_24a, 1'b1, "supply lamp lost");
		mreset();
		chk_bit(ind_24a, 1'b0, "supply lamp kept");
		// Conflict held across an outage
		field(12'h003, 12'h000, 12'hffc);
		conflict_tail();
		@(posedge mclk);
		line_ok <= 1'b0;
		repeat (3) @(posedge mclk);
		line_ok <= 1'b1;
		wait_ms(6010);
		chk_bit(stop_timing, 1'b1, "resumed after conflict");
		mreset();
		chk_bit(stop_timing, 1'b0, "flash after clear");
		print_verdict();
	end
endmodule
